// ==== hdl/acl_loop.sv ====
// Accumulator arithmetic loop: four accumulators, operand muxes, adder, multiply and divide.
`timescale 1ns/1ps
`include "acl_loop_regs.svh"
module acl_loop #(
    parameter int WIDTH = `ACL_WORD_WIDTH
) (
    input  wire logic                         clock,
    input  wire logic                         reset_n,
    input  wire logic                         loadEnableAccOne_n,
    input  wire logic                         strobeAccOne_n,
    input  wire logic                         clearAccOne_n,
    input  wire logic                         loadEnableAccTwo_n,
    input  wire logic                         strobeAccTwo_n,
    input  wire logic                         clearAccTwo_n,
    input  wire logic                         loadEnableSubOne_n,
    input  wire logic                         strobeSubOne_n,
    input  wire logic                         loadEnableSubTwo_n,
    input  wire logic                         strobeSubTwo_n,
    input  wire logic                         opaSelectHi,
    input  wire logic                         opaSelectLo,
    input  wire logic                         opaAddSelect_n,
    input  wire logic                         opaSubSelect_n,
    input  wire logic [2:0]                   opbSelect,
    input  wire logic [WIDTH-1:0]             memDataWord,
    input  wire logic [`ACL_IR_LOW_WIDTH-1:0] instrLowBits,
    input  wire logic [WIDTH-1:0]             otherSourceWord,
    input  wire logic                         swapJkWithRs,
    input  wire logic                         swapJK,
    input  wire logic                         multiplyStart,
    input  wire logic                         divideStart,
    output logic      [WIDTH-1:0]             accOne,
    output logic      [WIDTH-1:0]             accTwo,
    output logic      [WIDTH-1:0]             sumHold,
    output logic      [WIDTH-1:0]             divisorHold,
    output logic                              busy,
    output logic                              done
);
    acl_pkg::acl_state_type s;
    acl_pkg::acl_state_type next_s;

    logic [WIDTH-1:0] opaWord;
    logic [WIDTH-1:0] opbWord;
    logic [WIDTH-1:0] adderSum;
    logic             adderCarry;
    logic [WIDTH:0]   mulSum;
    logic [WIDTH:0]   divRem;
    logic [WIDTH+1:0] divTrial;

    // Operand A: the no-command code 00 selects memory data.
    always_comb begin
        unique case ({opaSelectHi, opaSelectLo})
            `ACL_OPA_MEMDATA: opaWord = memDataWord;
            `ACL_OPA_IRLOW:   opaWord = {{(WIDTH-`ACL_IR_LOW_WIDTH){1'b0}}, instrLowBits};
            `ACL_OPA_ACCTWO:  opaWord = s.accTwo;
            `ACL_OPA_ACCONE:  opaWord = s.accOne;
        endcase
    end

    // Operand B: either accumulator, either subaccumulator, or otherSourceWord for other codes.
    always_comb begin
        case (opbSelect)
            `ACL_OPB_ACCONE: opbWord = s.accOne;
            `ACL_OPB_ACCTWO: opbWord = s.accTwo;
            `ACL_OPB_SUBONE: opbWord = s.subOne;
            `ACL_OPB_SUBTWO: opbWord = s.subTwo;
            default:         opbWord = otherSourceWord;
        endcase
    end

    acl_adder #(
        .WIDTH(WIDTH)
    ) adder (
        .opaWord       (opaWord),
        .opaAddSelect_n(opaAddSelect_n),
        .opaSubSelect_n(opaSubSelect_n),
        .opbWord       (opbWord),
        .sum           (adderSum),
        .carry         (adderCarry)
    );

    // Multiply step: add multiplicand when the low multiplier bit is set.
    assign mulSum = {1'b0, s.subTwo} + (s.subOne[0] ? {1'b0, s.accTwo} : '0);
    // Divide step: trial subtraction of the held divisor from the shifted remainder.
    assign divRem   = {s.accTwo, s.accOne[WIDTH-1]};
    assign divTrial = {1'b0, divRem} - {2'b00, s.divisorHold};

    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        next_s.sumHold = adderSum;
        unique case (s.phase)
            acl_pkg::ACL_IDLE: begin
                if (multiplyStart) begin
                    next_s.subOne = s.accOne;
                    next_s.subTwo = '0;
                    next_s.count  = 4'h0;
                    next_s.phase  = acl_pkg::ACL_MUL;
                end else if (divideStart) begin
                    // The divisor is parked in divisorHold for the whole divide.
                    next_s.divisorHold = s.subOne;
                    next_s.count       = 4'h0;
                    next_s.phase       = acl_pkg::ACL_DIV;
                end else if (swapJkWithRs) begin
                    next_s.accOne = s.subOne;
                    next_s.subOne = s.accOne;
                    next_s.accTwo = s.subTwo;
                    next_s.subTwo = s.accTwo;
                end else if (swapJK) begin
                    next_s.accOne = s.accTwo;
                    next_s.accTwo = s.accOne;
                end else begin
                    if (!clearAccOne_n) begin
                        next_s.accOne = '0;
                    end else if (!strobeAccOne_n) begin
                        if (!loadEnableAccOne_n) begin
                            next_s.accOne = adderSum;
                        end else begin
                            next_s.accOne = {s.accOne[WIDTH-2:0], 1'b0};
                        end
                    end
                    if (!clearAccTwo_n) begin
                        next_s.accTwo = '0;
                    end else if (!strobeAccTwo_n) begin
                        if (!loadEnableAccTwo_n) begin
                            next_s.accTwo = adderSum;
                        end else begin
                            next_s.accTwo = {s.accTwo[WIDTH-2:0], 1'b0};
                        end
                    end
                    // Subaccumulators never take the adder sum, only their partners.
                    if (!strobeSubOne_n) begin
                        if (!loadEnableSubOne_n) begin
                            next_s.subOne = s.accOne;
                        end else begin
                            next_s.subOne = {s.subTwo[0], s.subOne[WIDTH-1:1]};
                        end
                    end
                    if (!strobeSubTwo_n) begin
                        if (!loadEnableSubTwo_n) begin
                            next_s.subTwo = s.accTwo;
                        end else begin
                            next_s.subTwo = {adderCarry, s.subTwo[WIDTH-1:1]};
                        end
                    end
                end
            end
            acl_pkg::ACL_MUL: begin
                next_s.subTwo = mulSum[WIDTH:1];
                next_s.subOne = {mulSum[0], s.subOne[WIDTH-1:1]};
                next_s.count  = s.count + 4'h1;
                if (s.count == `ACL_STEP_COUNT - 4'h1) begin
                    next_s.phase = acl_pkg::ACL_FINISH;
                    next_s.done  = 1'b1;
                end
            end
            acl_pkg::ACL_DIV: begin
                if (!divTrial[WIDTH+1]) begin
                    next_s.accTwo = divTrial[WIDTH-1:0];
                    next_s.accOne = {s.accOne[WIDTH-2:0], 1'b1};
                end else begin
                    next_s.accTwo = divRem[WIDTH-1:0];
                    next_s.accOne = {s.accOne[WIDTH-2:0], 1'b0};
                end
                next_s.count = s.count + 4'h1;
                if (s.count == `ACL_STEP_COUNT - 4'h1) begin
                    next_s.phase = acl_pkg::ACL_FINISH;
                    next_s.done  = 1'b1;
                end
            end
            acl_pkg::ACL_FINISH: begin
                next_s.phase = acl_pkg::ACL_IDLE;
            end
        endcase
        next_s.busy = (next_s.phase != acl_pkg::ACL_IDLE);
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // The primary accumulators, the held sum and the held divisor leave the block; the subaccumulators do not.
    assign accOne      = s.accOne;
    assign accTwo      = s.accTwo;
    assign sumHold     = s.sumHold;
    assign divisorHold = s.divisorHold;
    assign busy        = s.busy;
    assign done        = s.done;

    // Checks.
    logic idleQuiet;
    assign idleQuiet = (s.phase == acl_pkg::ACL_IDLE) && !multiplyStart && !divideStart
                       && !swapJkWithRs && !swapJK;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_clear_one: assert property (idleQuiet && !clearAccOne_n |=> s.accOne == '0)
        else $error("acc_one not cleared");
    a_clear_two: assert property (idleQuiet && !clearAccTwo_n |=> s.accTwo == '0)
        else $error("acc_two not cleared");
    a_load_one: assert property (idleQuiet && clearAccOne_n && !strobeAccOne_n
        && !loadEnableAccOne_n |=> s.accOne == $past(adderSum))
        else $error("acc_one did not load adder sum");
    a_shift_two: assert property (idleQuiet && clearAccTwo_n && !strobeAccTwo_n
        && loadEnableAccTwo_n |=> s.accTwo == {$past(s.accTwo[WIDTH-2:0]), 1'b0})
        else $error("acc_two did not shift left");
    a_hold_one: assert property (idleQuiet && clearAccOne_n && strobeAccOne_n
        |=> $stable(s.accOne))
        else $error("acc_one changed without command");
    a_sub_load: assert property (idleQuiet && !strobeSubOne_n && !loadEnableSubOne_n
        |=> s.subOne == $past(s.accOne))
        else $error("sub_acc_one did not load acc_one");
    a_sub_chain: assert property (idleQuiet && !strobeSubOne_n && loadEnableSubOne_n
        |=> s.subOne[WIDTH-1] == $past(s.subTwo[0]))
        else $error("shift chain broken");
    a_sub_hold: assert property (idleQuiet && strobeSubOne_n && strobeSubTwo_n
        |=> $stable(s.subOne) && $stable(s.subTwo))
        else $error("subaccumulator written without command");
    a_swap_pairs: assert property ((s.phase == acl_pkg::ACL_IDLE) && !multiplyStart
        && !divideStart && swapJkWithRs
        |=> s.accOne == $past(s.subOne) && s.subTwo == $past(s.accTwo))
        else $error("pair exchange wrong");
    a_feed_through: assert property (opaAddSelect_n && opaSubSelect_n |->
        adderSum == opbWord)
        else $error("feed through wrong");
    a_sub_twos: assert property (!opaSubSelect_n && opaAddSelect_n && opaSelectHi
        && opaSelectLo && opbSelect == `ACL_OPB_ACCTWO |-> adderSum == s.accTwo - s.accOne)
        else $error("subtract wrong");
    a_mul_product: assert property ((s.phase == acl_pkg::ACL_IDLE) && multiplyStart
        |-> ##13 done && {s.subTwo, s.subOne}
        == {{WIDTH{1'b0}}, $past(s.accTwo, 13)} * {{WIDTH{1'b0}}, $past(s.accOne, 13)})
        else $error("product wrong");
    a_div_result: assert property ((s.phase == acl_pkg::ACL_IDLE) && !multiplyStart
        && divideStart && s.subOne != '0 && s.accTwo < s.subOne
        |-> ##13 done && s.accOne == WIDTH'({$past(s.accTwo, 13), $past(s.accOne, 13)}
        / {{WIDTH{1'b0}}, $past(s.subOne, 13)}))
        else $error("quotient wrong");

    // Sequencer results and timing.
    a_div_rem: assert property ((s.phase == acl_pkg::ACL_IDLE) && !multiplyStart
        && divideStart && s.subOne != '0 && s.accTwo < s.subOne
        |-> ##13 s.accTwo == WIDTH'({$past(s.accTwo, 13), $past(s.accOne, 13)}
        % {{WIDTH{1'b0}}, $past(s.subOne, 13)}))
        else $error("remainder wrong");
    a_step_bound: assert property (s.phase == acl_pkg::ACL_DIV
        |-> s.count < `ACL_STEP_COUNT)
        else $error("divide ran past its steps");
    a_div_load: assert property ((s.phase == acl_pkg::ACL_IDLE) && !multiplyStart
        && divideStart |=> s.divisorHold == $past(s.subOne))
        else $error("divisor not parked");
    a_div_hold: assert property (s.phase == acl_pkg::ACL_DIV
        |=> $stable(s.divisorHold))
        else $error("divisor changed during divide");
    a_div_busy: assert property ((s.phase == acl_pkg::ACL_IDLE) && !multiplyStart
        && divideStart |=> s.busy [*8] ##1 s.busy [*5] ##1 !s.busy)
        else $error("divide busy span wrong");
    a_mul_busy: assert property ((s.phase == acl_pkg::ACL_IDLE) && multiplyStart
        |=> s.busy [*8] ##1 s.busy [*5] ##1 !s.busy)
        else $error("multiply busy span wrong");

    // Primary accumulators must not move while a multiply runs, whatever the strobes do.
    a_mul_keep: assert property (s.phase == acl_pkg::ACL_MUL
        |=> $stable(s.accOne) && $stable(s.accTwo))
        else $error("accumulator changed during multiply");
    a_finish_idle: assert property (s.phase == acl_pkg::ACL_FINISH
        |=> s.phase == acl_pkg::ACL_IDLE && !s.busy)
        else $error("sequence did not return to idle");
    a_done_pulse: assert property (done |=> !done)
        else $error("done held longer than one cycle");

    // Strobed register behaviour and exchanges while the sequencer is idle.
    a_load_two: assert property (idleQuiet && clearAccTwo_n && !strobeAccTwo_n
        && !loadEnableAccTwo_n |=> s.accTwo == $past(adderSum))
        else $error("acc_two did not load adder sum");
    a_shift_one: assert property (idleQuiet && clearAccOne_n && !strobeAccOne_n
        && loadEnableAccOne_n |=> s.accOne == {$past(s.accOne[WIDTH-2:0]), 1'b0})
        else $error("acc_one did not shift left");
    a_hold_two: assert property (idleQuiet && clearAccTwo_n && strobeAccTwo_n
        |=> $stable(s.accTwo))
        else $error("acc_two changed without command");
    a_sub_load_two: assert property (idleQuiet && !strobeSubTwo_n
        && !loadEnableSubTwo_n |=> s.subTwo == $past(s.accTwo))
        else $error("sub_acc_two did not load acc_two");
    // The top of sub_acc_two takes the adder carry on a free-standing right shift.
    a_sub_shift: assert property (idleQuiet && !strobeSubTwo_n && loadEnableSubTwo_n
        |=> s.subTwo == {$past(adderCarry), $past(s.subTwo[WIDTH-1:1])})
        else $error("sub_acc_two did not shift right");
    a_swap_rest: assert property ((s.phase == acl_pkg::ACL_IDLE) && !multiplyStart
        && !divideStart && swapJkWithRs
        |=> s.accTwo == $past(s.subTwo) && s.subOne == $past(s.accOne))
        else $error("pair exchange incomplete");
    a_swap_accs: assert property ((s.phase == acl_pkg::ACL_IDLE) && !multiplyStart
        && !divideStart && !swapJkWithRs && swapJK
        |=> s.accOne == $past(s.accTwo) && s.accTwo == $past(s.accOne))
        else $error("acc exchange wrong");

    // Operand selection and the adder.
    a_opa_memdata: assert property ({opaSelectHi, opaSelectLo} == `ACL_OPA_MEMDATA
        |-> opaWord == memDataWord)
        else $error("operand A did not select memory data");
    a_opa_irlow: assert property ({opaSelectHi, opaSelectLo} == `ACL_OPA_IRLOW
        |-> opaWord == {{(WIDTH-`ACL_IR_LOW_WIDTH){1'b0}}, instrLowBits})
        else $error("operand A did not select instruction bits");
    a_opa_acc: assert property ({opaSelectHi, opaSelectLo} == `ACL_OPA_ACCONE
        |-> opaWord == s.accOne)
        else $error("operand A did not select acc_one");
    a_add_sum: assert property (!opaAddSelect_n |-> adderSum == opaWord + opbWord)
        else $error("adder sum wrong");
    a_sum_hold: assert property (1'b1 |=> sumHold == $past(adderSum))
        else $error("held sum wrong");

    c_multiply: cover property ((s.phase == acl_pkg::ACL_IDLE) && multiplyStart ##13 done);
    c_divide: cover property ((s.phase == acl_pkg::ACL_IDLE) && !multiplyStart
        && divideStart ##13 done);
    c_swap_then_swap: cover property (idleQuiet ##1 swapJkWithRs ##2 swapJK);
    c_sub_shift: cover property (idleQuiet && !strobeSubTwo_n && loadEnableSubTwo_n);
    c_subtract: cover property (!opaSubSelect_n && opaAddSelect_n && !strobeAccOne_n);
endmodule // acl_loop

// ==== hdl/acl_loop_regs.svh ====
// Constants for the accumulator arithmetic loop.
`ifndef ACL_LOOP_REGS_SVH
`define ACL_LOOP_REGS_SVH

`define ACL_WORD_WIDTH   12
`define ACL_IR_LOW_WIDTH 6
`define ACL_STEP_COUNT   4'hc

`define ACL_OPA_MEMDATA  2'h0
`define ACL_OPA_IRLOW    2'h1
`define ACL_OPA_ACCTWO   2'h2
`define ACL_OPA_ACCONE   2'h3

`define ACL_OPB_ACCONE   3'h0
`define ACL_OPB_ACCTWO   3'h1
`define ACL_OPB_SUBONE   3'h2
`define ACL_OPB_SUBTWO   3'h3
`define ACL_OPB_OTHER    3'h4

`endif

// ==== hdl/acl_pkg.sv ====
// Types shared by the accumulator arithmetic loop.
package acl_pkg;
`include "acl_loop_regs.svh"

    typedef enum logic [1:0] {
        ACL_IDLE   = 2'h0,
        ACL_MUL    = 2'h1,
        ACL_DIV    = 2'h2,
        ACL_FINISH = 2'h3
    } acl_phase_type;

    typedef struct packed {
        logic [`ACL_WORD_WIDTH-1:0] accOne;
        logic [`ACL_WORD_WIDTH-1:0] accTwo;
        logic [`ACL_WORD_WIDTH-1:0] subOne;
        logic [`ACL_WORD_WIDTH-1:0] subTwo;
        logic [`ACL_WORD_WIDTH-1:0] divisorHold;
        logic [`ACL_WORD_WIDTH-1:0] sumHold;
        logic [3:0]                 count;
        acl_phase_type              phase;
        logic                       busy;
        logic                       done;
    } acl_state_type;
endpackage

// ==== hdl/acl_adder.sv ====
// Operand A add/subtract gating and the word adder.
`timescale 1ns/1ps
module acl_adder #(
    parameter int WIDTH = 12
) (
    input  wire logic [WIDTH-1:0] opaWord,
    input  wire logic             opaAddSelect_n,
    input  wire logic             opaSubSelect_n,
    input  wire logic [WIDTH-1:0] opbWord,
    output logic      [WIDTH-1:0] sum,
    output logic                  carry
);
    logic [WIDTH-1:0] gated;
    logic             carryIn;

    always_comb begin
        // Add wins if both are asserted; neither gives zeros for feed through.
        if (!opaAddSelect_n) begin
            gated = opaWord;
        end else if (!opaSubSelect_n) begin
            gated = ~opaWord;
        end else begin
            gated = '0;
        end
        carryIn = opaAddSelect_n & ~opaSubSelect_n;
        {carry, sum} = {1'b0, gated} + {1'b0, opbWord} + (WIDTH+1)'(carryIn);
    end
endmodule // acl_adder

// ==== tb/acl_ctrl_model.sv ====
// Control-unit model that drives the loop's command and operand lines.
`timescale 1ns/1ps
module acl_ctrl_model (
    input  wire logic        clock,
    output logic      [20:0] ctl,
    output logic      [11:0] other
);
    localparam logic [20:0] IDLE = 21'h0033ff;

    initial begin
        ctl   = IDLE;
        other = 12'h000;
    end

    // Lines change just after an edge and are taken at the next one, then ctl is released to IDLE; other keeps its value.
    task automatic pulse(input logic [20:0] v, input logic [11:0] w);
        @(posedge clock);
        ctl   <= v;
        other <= w;
        @(posedge clock);
        ctl   <= IDLE;
    endtask

    // Mode 0 feeds operand B straight through, 1 adds, 2 subtracts; dest 0 is acc_one.
    task automatic arith(input logic [1:0] opa, input logic [1:0] mode,
                         input logic [2:0] opb, input logic dest, input logic [11:0] w);
        logic [20:0] v;
        v        = IDLE;
        v[10]    = opa[1];
        v[11]    = opa[0];
        v[12]    = (mode != 2'h1);
        v[13]    = (mode != 2'h2);
        v[16:14] = opb;
        v[4:3]   = dest ? 2'h0 : 2'h3;
        v[1:0]   = dest ? 2'h3 : 2'h0;
        pulse(v, w);
    endtask

    // The divisor reaches sub_acc_one only by way of acc_one.
    task automatic divide_setup(input logic [11:0] dvs, input logic [23:0] dvd);
        arith(2'h0, 2'h0, 3'h4, 1'b0, dvs);
        pulse(IDLE & ~21'h0000c0, 12'h000);
        arith(2'h0, 2'h0, 3'h4, 1'b1, dvd[23:12]);
        arith(2'h0, 2'h0, 3'h4, 1'b0, dvd[11:0]);
    endtask
endmodule // acl_ctrl_model

// ==== tb/tb_acl_loop.sv ====
// Self-checking testbench for the accumulator arithmetic loop.
`timescale 1ns/1ps
module tb_acl_loop;
    localparam logic [20:0] IDLE = 21'h0033ff;
    localparam logic [11:0] MEMV = 12'ha5c;
    localparam logic [5:0]  IRLO = 6'h2b;
    localparam logic [11:0] SEL_EXP [4] = '{12'ha5d, 12'h02c, 12'h57a, 12'h57b};
    logic        clock;
    logic        reset_n;
    logic [20:0] ctl;
    logic [11:0] other;
    logic [11:0] accOne;
    logic [11:0] accTwo;
    logic [11:0] sumHold;
    logic [11:0] divisorHold;
    logic        busy;
    logic        done;
    int          n_fail;
    int          checks_done;

    acl_ctrl_model u_ctrl (.clock(clock), .ctl(ctl), .other(other));

    acl_loop u_dut (
        .clock              (clock),
        .reset_n            (reset_n),
        .loadEnableAccOne_n (ctl[0]),
        .strobeAccOne_n     (ctl[1]),
        .clearAccOne_n      (ctl[2]),
        .loadEnableAccTwo_n (ctl[3]),
        .strobeAccTwo_n     (ctl[4]),
        .clearAccTwo_n      (ctl[5]),
        .loadEnableSubOne_n (ctl[6]),
        .strobeSubOne_n     (ctl[7]),
        .loadEnableSubTwo_n (ctl[8]),
        .strobeSubTwo_n     (ctl[9]),
        .opaSelectHi        (ctl[10]),
        .opaSelectLo        (ctl[11]),
        .opaAddSelect_n     (ctl[12]),
        .opaSubSelect_n     (ctl[13]),
        .opbSelect          (ctl[16:14]),
        .memDataWord        (MEMV),
        .instrLowBits       (IRLO),
        .otherSourceWord    (other),
        .swapJkWithRs       (ctl[17]),
        .swapJK             (ctl[18]),
        .multiplyStart      (ctl[19]),
        .divideStart        (ctl[20]),
        .accOne             (accOne),
        .accTwo             (accTwo),
        .sumHold            (sumHold),
        .divisorHold        (divisorHold),
        .busy               (busy),
        .done               (done)
    );

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Counts cycles from the start edge so the latency itself can be judged.
    task automatic wait_done(input int first, output int n);
        n = first;
        #1;
        while (done !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic t_add_sub;
        check(accOne | accTwo, 12'h000);
        u_ctrl.arith(2'h0, 2'h0, 3'h4, 1'b0, 12'h123);
        u_ctrl.arith(2'h0, 2'h0, 3'h4, 1'b1, 12'h456);
        #1;
        check(accTwo, 12'h456);
        u_ctrl.arith(2'h3, 2'h1, 3'h1, 1'b1, 12'h000);
        #1;
        check(accTwo, 12'h579);
        check(sumHold, 12'h579);
        u_ctrl.arith(2'h3, 2'h2, 3'h1, 1'b0, 12'h000);
        #1;
        check(accOne, 12'h456);
        for (int s = 0; s < 4; s++) begin
            u_ctrl.arith(2'(s), 2'h1, 3'h4, 1'b0, 12'h001);
            #1;
            check(accOne, SEL_EXP[s]);
        end
        $display("add and subtract finished");
    endtask

    task automatic t_shift_clear;
        u_ctrl.arith(2'h0, 2'h0, 3'h4, 1'b0, 12'h801);
        u_ctrl.arith(2'h0, 2'h0, 3'h4, 1'b1, 12'h803);
        u_ctrl.pulse(IDLE & ~21'h000012, 12'h000);
        #1;
        check(accOne, 12'h002);
        check(accTwo, 12'h006);
        u_ctrl.pulse(IDLE & ~21'h000036, 12'h000);
        repeat (3) @(posedge clock);
        #1;
        check(accOne, 12'h000);
        check(accTwo, 12'h000);
        $display("shift and clear finished");
    endtask

    task automatic t_multiply;
        logic [23:0] prod;
        int          n;
        prod = 24'hfff * 24'hffe;
        u_ctrl.arith(2'h0, 2'h0, 3'h4, 1'b0, 12'hfff);
        u_ctrl.arith(2'h0, 2'h0, 3'h4, 1'b1, 12'hffe);
        u_ctrl.pulse(IDLE | 21'h080000, 12'h000);
        // A clear issued while busy must be ignored.
        u_ctrl.pulse(IDLE & ~21'h000024, 12'h000);
        wait_done(3, n);
        check(12'(n), 12'h00d);
        check(accOne ^ accTwo, 12'h001);
        @(posedge clock);
        #1;
        check({10'h000, busy, done}, 12'h000);
        u_ctrl.pulse(IDLE | 21'h020000, 12'h000);
        #1;
        check(accTwo, prod[23:12]);
        check(accOne, prod[11:0]);
        u_ctrl.pulse(IDLE | 21'h020000, 12'h000);
        u_ctrl.pulse(IDLE | 21'h040000, 12'h000);
        #1;
        check(accOne, 12'hffe);
        check(accTwo, 12'hfff);
        $display("multiply and exchange finished");
    endtask

    task automatic t_divide;
        logic [23:0] dvd;
        int          n;
        dvd = 24'h123456;
        u_ctrl.divide_setup(12'h400, dvd);
        u_ctrl.pulse(IDLE | 21'h100000, 12'h000);
        wait_done(1, n);
        check(12'(n), 12'h00d);
        check(accOne, 12'(dvd / 24'h000400));
        check(accTwo, 12'(dvd % 24'h000400));
        check(divisorHold, 12'h400);
        $display("divide finished");
    endtask

    task automatic t_sub_path;
        u_ctrl.arith(2'h0, 2'h0, 3'h4, 1'b0, 12'h1a7);
        u_ctrl.arith(2'h0, 2'h0, 3'h4, 1'b1, 12'h3c5);
        u_ctrl.pulse(IDLE & ~21'h0003c0, 12'h000);
        u_ctrl.arith(2'h0, 2'h0, 3'h3, 1'b0, 12'h000);
        u_ctrl.arith(2'h0, 2'h0, 3'h2, 1'b1, 12'h000);
        #1;
        check(accOne, 12'h3c5);
        check(accTwo, 12'h1a7);
        u_ctrl.pulse(IDLE & ~21'h000280, 12'h000);
        u_ctrl.arith(2'h0, 2'h0, 3'h3, 1'b0, 12'h000);
        u_ctrl.arith(2'h0, 2'h0, 3'h2, 1'b1, 12'h000);
        #1;
        check(accOne, 12'h1e2);
        check(accTwo, 12'h8d3);
        $display("subaccumulator path finished");
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (2000) @(posedge clock);
        n_fail++;
        stop_test;
    end

    initial begin
        n_fail      = 0;
        checks_done = 0;
        reset_n     = 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        #1;
        t_add_sub;
        t_shift_clear;
        t_multiply;
        t_divide;
        t_sub_path;
        stop_test;
    end
endmodule // tb_acl_loop
